// file: hdl/pmtb_map.svh
// Register offsets, field positions, reset values and keys of the PWM time base.
// Assumes a 32-bit register port with word-aligned byte addresses.
`ifndef PMTB_MAP_SVH
`define PMTB_MAP_SVH

`define PMTB_ADDR_PERIOD    8'h00
`define PMTB_ADDR_COMPARE   8'h04
`define PMTB_ADDR_COUNT     8'h08
`define PMTB_ADDR_KEY       8'h0c
`define PMTB_ADDR_OUTCTL    8'h10
`define PMTB_ADDR_DUTY      8'h14
`define PMTB_ADDR_STATUS    8'h18

`define PMTB_KEY_FIRST      16'habcd
`define PMTB_KEY_SECOND     16'h4321

`define PMTB_RESET_PERIOD   16'hffff
`define PMTB_RESET_COMPARE  16'h0000
`define PMTB_RESET_OUTCTL   16'h0000
`define PMTB_RESET_DUTY     16'h0000

`define PMTB_STATUS_UNLOCK  0
`define PMTB_STATUS_LOCKCFG 1
`define PMTB_STATUS_REJECT  2

`endif

// file: hdl/pmtb_pkg.sv
// Types shared by the PWM master time base files.
// Assumes the map header supplies the numeric constants.
`default_nettype none
package pmtb_pkg;
    typedef logic [7:0]  pmtb_addr_type;
    typedef logic [31:0] pmtb_word_type;
    typedef logic [15:0] pmtb_half_type;
    typedef enum logic [1:0] {
        pmtb_key_idle,
        pmtb_key_half,
        pmtb_key_open
    } pmtb_key_state_type;
endpackage
`default_nettype wire

// file: hdl/pmtb_counter.sv
// Master time base counter with period wrap and compare match.
// Assumes period and compare come from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none
module pmtb_counter (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire pmtb_pkg::pmtb_half_type period,
    input  wire pmtb_pkg::pmtb_half_type compare,
    output var  pmtb_pkg::pmtb_half_type count,
    output var  logic                   match
);
    import pmtb_pkg::*;

    // One PWM clock is one system clock here, so each count lasts one system clock.
    always_ff @(posedge clk) begin
        if (reset) begin
            count <= 16'h0000;
        end else if (count >= period) begin
            count <= 16'h0000;
        end else begin
            count <= count + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            match <= 1'b0;
        end else begin
            match <= (count == compare);
        end
    end
endmodule // pmtb_counter
`default_nettype wire

// file: hdl/pmtb_timebase.sv
// PWM master time base with special event trigger and output-control lock.
// Assumes a single-cycle register port and a lock option pin from the
// configuration word, stable after reset.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pmtb_map.svh"
module pmtb_timebase (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire pmtb_pkg::pmtb_addr_type address,
    input  wire pmtb_pkg::pmtb_word_type write_data,
    input  wire logic                   write_strobe,
    input  wire logic                   read_strobe,
    input  wire logic                   lock_option_present,
    input  wire logic                   output_lock_config_bit,
    output var  pmtb_pkg::pmtb_word_type read_data,
    output var  logic                   special_event_trigger,
    output var  pmtb_pkg::pmtb_half_type output_control_regs,
    output var  pmtb_pkg::pmtb_half_type primary_duty_cycle
);
    import pmtb_pkg::*;

    pmtb_half_type      time_base_period;
    pmtb_half_type      special_event_compare;
    pmtb_half_type      master_time_count;
    pmtb_key_state_type key_state;
    logic               compare_match;
    logic               lock_meta;
    logic               lock_sync;
    logic               present_meta;
    logic               present_sync;
    logic               reject_flag;
    logic               access;
    logic               key_write;
    logic               outctl_write;
    logic               locked;

    function automatic logic hit(input pmtb_addr_type a,
                                 input pmtb_addr_type r);
        hit = (a == r);
    endfunction

    // Configuration pins come from outside the clock domain.
    always_ff @(posedge clk) begin
        if (reset) begin
            lock_meta    <= 1'b0;
            lock_sync    <= 1'b0;
            present_meta <= 1'b0;
            present_sync <= 1'b0;
        end else begin
            lock_meta    <= output_lock_config_bit;
            lock_sync    <= lock_meta;
            present_meta <= lock_option_present;
            present_sync <= present_meta;
        end
    end

    assign access       = write_strobe | read_strobe;
    assign key_write    = write_strobe & present_sync
                        & hit(address, `PMTB_ADDR_KEY);
    assign outctl_write = write_strobe & hit(address, `PMTB_ADDR_OUTCTL);
    // Lock applies only when the option exists and the bit is zero.
    assign locked       = present_sync & ~lock_sync;

    pmtb_counter u_counter (
        .clk     (clk),
        .reset   (reset),
        .period  (time_base_period),
        .compare (special_event_compare),
        .count   (master_time_count),
        .match   (compare_match)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            special_event_trigger <= 1'b0;
        end else begin
            special_event_trigger <= compare_match;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            time_base_period      <= `PMTB_RESET_PERIOD;
            special_event_compare <= `PMTB_RESET_COMPARE;
            primary_duty_cycle    <= `PMTB_RESET_DUTY;
        end else if (write_strobe) begin
            if (hit(address, `PMTB_ADDR_PERIOD)) begin
                time_base_period <= write_data[15:0];
            end
            if (hit(address, `PMTB_ADDR_COMPARE)) begin
                special_event_compare <= write_data[15:0];
            end
            if (hit(address, `PMTB_ADDR_DUTY)) begin
                primary_duty_cycle <= write_data[15:0];
            end
        end
    end

    // Unlock sequence: any access in the open state leaves it, so the protected
    // write only lands as the very next access after the second key.
    always_ff @(posedge clk) begin
        if (reset) begin
            key_state <= pmtb_key_idle;
        end else if (access) begin
            case (key_state)
                pmtb_key_idle: begin
                    if (key_write && write_data[15:0] == `PMTB_KEY_FIRST) begin
                        key_state <= pmtb_key_half;
                    end
                end
                pmtb_key_half: begin
                    if (key_write && write_data[15:0] == `PMTB_KEY_SECOND) begin
                        key_state <= pmtb_key_open;
                    end else if (key_write &&
                                 write_data[15:0] == `PMTB_KEY_FIRST) begin
                        key_state <= pmtb_key_half;
                    end else begin
                        key_state <= pmtb_key_idle;
                    end
                end
                pmtb_key_open: begin
                    // A fresh first key starts a new sequence at once.
                    if (key_write && write_data[15:0] == `PMTB_KEY_FIRST) begin
                        key_state <= pmtb_key_half;
                    end else begin
                        key_state <= pmtb_key_idle;
                    end
                end
                default: begin
                    key_state <= pmtb_key_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            output_control_regs <= `PMTB_RESET_OUTCTL;
        end else if (outctl_write &&
                     (!locked || key_state == pmtb_key_open)) begin
            output_control_regs <= write_data[15:0];
        end
    end

    // Sticky record of a refused protected write; cleared by reading status.
    always_ff @(posedge clk) begin
        if (reset) begin
            reject_flag <= 1'b0;
        end else if (outctl_write && locked && key_state != pmtb_key_open) begin
            reject_flag <= 1'b1;
        end else if (read_strobe && hit(address, `PMTB_ADDR_STATUS)) begin
            reject_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            read_data <= 32'h0000_0000;
        end else if (read_strobe) begin
            case (address)
                `PMTB_ADDR_PERIOD:  read_data <= {16'h0000, time_base_period};
                `PMTB_ADDR_COMPARE: read_data <= {16'h0000,
                                                  special_event_compare};
                `PMTB_ADDR_COUNT:   read_data <= {16'h0000,
                                                  master_time_count};
                `PMTB_ADDR_KEY:     read_data <= 32'h0000_0000;
                `PMTB_ADDR_OUTCTL:  read_data <= {16'h0000,
                                                  output_control_regs};
                `PMTB_ADDR_DUTY:    read_data <= {16'h0000, primary_duty_cycle};
                `PMTB_ADDR_STATUS: begin
                    read_data <= 32'h0000_0000;
                    read_data[`PMTB_STATUS_UNLOCK]  <=
                        (key_state == pmtb_key_open);
                    read_data[`PMTB_STATUS_LOCKCFG] <= locked;
                    read_data[`PMTB_STATUS_REJECT]  <= reject_flag;
                end
                default: read_data <= 32'h0000_0000;
            endcase
        end else begin
            read_data <= 32'h0000_0000;
        end
    end
endmodule // pmtb_timebase
`default_nettype wire

// file: verif/pmtb_timebase_sva.sv
// Concurrent checks on the ports of the PWM master time base.
// Assumes it is bound to pmtb_timebase and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "pmtb_map.svh"
module pmtb_timebase_sva (
    input wire logic                    clk,
    input wire logic                    reset,
    input wire pmtb_pkg::pmtb_addr_type address,
    input wire pmtb_pkg::pmtb_word_type write_data,
    input wire logic                    write_strobe,
    input wire logic                    read_strobe,
    input wire logic                    lock_option_present,
    input wire logic                    output_lock_config_bit,
    input wire pmtb_pkg::pmtb_word_type read_data,
    input wire logic                    special_event_trigger,
    input wire pmtb_pkg::pmtb_half_type output_control_regs,
    input wire pmtb_pkg::pmtb_half_type primary_duty_cycle
);
    import pmtb_pkg::*;
    wire logic wk = write_strobe && address == `PMTB_ADDR_KEY;
    wire logic wo = write_strobe && address == `PMTB_ADDR_OUTCTL;
    wire logic wd = write_strobe && address == `PMTB_ADDR_DUTY;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_read_upper_zero: assert property (read_data[31:16] == 16'h0)
        else $error("read data upper half not zero");
    a_key_reads_zero: assert property (
        $past(read_strobe && address == `PMTB_ADDR_KEY) |-> read_data == 0)
        else $error("key register read not zero");
    a_read_idle_zero: assert property (!$past(read_strobe) |-> read_data == 0)
        else $error("read data not zero outside answer cycle");
    a_outctl_hold: assert property (
        !$past(wo) |-> $stable(output_control_regs))
        else $error("output control changed without a write");
    a_outctl_free: assert property (
        $past(wo && output_lock_config_bit)
        |-> output_control_regs == $past(write_data[15:0]))
        else $error("unlocked output control write lost");
    a_unlock_sequence: assert property (
        (wk && lock_option_present && write_data[15:0] == `PMTB_KEY_FIRST)
        ##1 (wk && write_data[15:0] == `PMTB_KEY_SECOND) ##1 wo
        |=> output_control_regs == $past(write_data[15:0]))
        else $error("write after unlock sequence not accepted");
    a_duty_write: assert property (
        $past(wd) |-> primary_duty_cycle == $past(write_data[15:0]))
        else $error("duty register write lost");
    a_trigger_single: assert property (special_event_trigger |=> !special_event_trigger)
        else $error("trigger longer than one cycle");
endmodule // pmtb_timebase_sva
`default_nettype wire

// file: verif/pmtb_timebase_tb_top.sv
// Self-checking bench for the PWM master time base block.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "pmtb_map.svh"
module pmtb_timebase_tb_top;
    import pmtb_pkg::*;
    logic          clk = 1'b0;
    logic          reset = 1'b1;
    pmtb_addr_type address = 8'h00;
    pmtb_word_type write_data = 32'h0;
    logic          write_strobe = 1'b0;
    logic          read_strobe = 1'b0;
    logic          lock_option_present = 1'b1;
    logic          output_lock_config_bit = 1'b0;
    pmtb_word_type read_data;
    logic          special_event_trigger;
    pmtb_half_type output_control_regs;
    pmtb_half_type primary_duty_cycle;
    int            error_cnt = 0;
    int            compares = 0;
    int            n;
    int            gap;
    pmtb_word_type g1;
    pmtb_word_type g2;
    always #50 clk = ~clk;
    pmtb_timebase u_pmtb_timebase (.clk(clk), .reset(reset),
        .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe),
        .lock_option_present(lock_option_present),
        .output_lock_config_bit(output_lock_config_bit),
        .read_data(read_data), .special_event_trigger(special_event_trigger),
        .output_control_regs(output_control_regs),
        .primary_duty_cycle(primary_duty_cycle));
    task automatic check(input pmtb_word_type got, input pmtb_word_type exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("Compares %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // The lock strap only changes while reset is held, as it would on a part.
    task automatic restart(input logic lock_bit, input logic present);
        @(posedge clk);
        reset <= 1'b1;
        write_strobe <= 1'b0;
        output_lock_config_bit <= lock_bit;
        lock_option_present <= present;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // The strobe stays high so that writes can follow each other with no gap.
    task automatic wr(input pmtb_addr_type a, input pmtb_half_type d);
        @(posedge clk);
        read_strobe <= 1'b0;
        write_strobe <= 1'b1;
        address <= a;
        write_data <= {16'h0, d};
    endtask
    task automatic rd(input pmtb_addr_type a, output pmtb_word_type got);
        @(posedge clk);
        write_strobe <= 1'b0;
        read_strobe <= 1'b1;
        address <= a;
        @(posedge clk);
        read_strobe <= 1'b0;
        @(negedge clk);
        got = read_data;
    endtask
    task automatic rdc(input pmtb_addr_type a, input pmtb_word_type exp);
        pmtb_word_type got;
        rd(a, got);
        check(got, exp);
    endtask
    initial begin
        restart(1'b0, 1'b1);
        rdc(`PMTB_ADDR_PERIOD, 32'h0000ffff);
        rdc(`PMTB_ADDR_COMPARE, 32'h0);
        rdc(`PMTB_ADDR_KEY, 32'h0);
        rdc(`PMTB_ADDR_DUTY, 32'h0);
        wr(`PMTB_ADDR_OUTCTL, 16'h1111);
        rdc(`PMTB_ADDR_STATUS, 32'h6);
        rdc(`PMTB_ADDR_STATUS, 32'h2);
        check({16'h0, output_control_regs}, 32'h0);
        wr(`PMTB_ADDR_KEY, `PMTB_KEY_FIRST);
        wr(`PMTB_ADDR_KEY, `PMTB_KEY_SECOND);
        wr(`PMTB_ADDR_OUTCTL, 16'h5a5a);
        rdc(`PMTB_ADDR_STATUS, 32'h2);
        check({16'h0, output_control_regs}, 32'h5a5a);
        wr(`PMTB_ADDR_KEY, `PMTB_KEY_FIRST);
        wr(`PMTB_ADDR_KEY, 16'h1234);
        wr(`PMTB_ADDR_KEY, `PMTB_KEY_SECOND);
        wr(`PMTB_ADDR_OUTCTL, 16'h0f0f);
        rdc(`PMTB_ADDR_STATUS, 32'h6);
        wr(`PMTB_ADDR_KEY, `PMTB_KEY_FIRST);
        wr(`PMTB_ADDR_KEY, `PMTB_KEY_SECOND);
        rd(`PMTB_ADDR_COUNT, g1);
        wr(`PMTB_ADDR_OUTCTL, 16'h0f0f);
        rdc(`PMTB_ADDR_STATUS, 32'h6);
        check({16'h0, output_control_regs}, 32'h5a5a);
        wr(`PMTB_ADDR_KEY, `PMTB_KEY_FIRST);
        wr(`PMTB_ADDR_KEY, `PMTB_KEY_SECOND);
        wr(`PMTB_ADDR_KEY, `PMTB_KEY_FIRST);
        wr(`PMTB_ADDR_KEY, `PMTB_KEY_SECOND);
        wr(`PMTB_ADDR_OUTCTL, 16'ha5a5);
        rdc(`PMTB_ADDR_OUTCTL, 32'h0000a5a5);
        wr(`PMTB_ADDR_DUTY, 16'hbeef);
        rdc(`PMTB_ADDR_DUTY, 32'h0000beef);
        wr(`PMTB_ADDR_PERIOD, 16'h0004);
        wr(`PMTB_ADDR_COMPARE, 16'h0002);
        rd(`PMTB_ADDR_COUNT, g1);
        rd(`PMTB_ADDR_COUNT, g2);
        check(g1 % 5, g1);
        check(g2, (g1 + 2) % 5);
        n = 0;
        while (special_event_trigger !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (special_event_trigger !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: trigger never seen", $time);
            conclude;
        end
        gap = 0;
        do begin
            @(negedge clk);
            gap++;
        end while (special_event_trigger !== 1'b1 && gap < 20);
        check(gap, 32'd5);
        rdc(`PMTB_ADDR_COUNT, 32'h0);
        restart(1'b1, 1'b1);
        wr(`PMTB_ADDR_OUTCTL, 16'h3c3c);
        rdc(`PMTB_ADDR_STATUS, 32'h0);
        check({16'h0, output_control_regs}, 32'h3c3c);
        restart(1'b0, 1'b0);
        wr(`PMTB_ADDR_KEY, `PMTB_KEY_FIRST);
        wr(`PMTB_ADDR_KEY, `PMTB_KEY_SECOND);
        rdc(`PMTB_ADDR_STATUS, 32'h0);
        wr(`PMTB_ADDR_OUTCTL, 16'h7e7e);
        rdc(`PMTB_ADDR_OUTCTL, 32'h00007e7e);
        conclude;
    end
endmodule // pmtb_timebase_tb_top
bind pmtb_timebase pmtb_timebase_sva u_pmtb_timebase_sva (.clk(clk),
    .reset(reset), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .lock_option_present(lock_option_present),
    .output_lock_config_bit(output_lock_config_bit),
    .read_data(read_data), .special_event_trigger(special_event_trigger),
    .output_control_regs(output_control_regs),
    .primary_duty_cycle(primary_duty_cycle));
`default_nettype wire
